// ===== inc/sactc_pkg.sv
package sactc_pkg;
	localparam logic [7:0] OFS_SC1 = 8'h00;
	localparam logic [7:0] OFS_SC2 = 8'h04;
	localparam logic [7:0] OFS_RH  = 8'h08;
	localparam logic [7:0] OFS_RL  = 8'h0c;
	localparam logic [7:0] OFS_CVH = 8'h10;
	localparam logic [7:0] OFS_CVL = 8'h14;
	localparam logic [7:0] OFS_CFG = 8'h18;
	localparam logic [4:0] CH_OFF  = 5'h1f;
	localparam logic [4:0] CH_TEMP = 5'h1a;
	localparam logic [4:0] CH_BGAP = 5'h1b;
	localparam logic [1:0] SRC_BUS  = 2'h0;
	localparam logic [1:0] SRC_BUS2 = 2'h1;
	localparam logic [1:0] SRC_ALT  = 2'h2;
	localparam logic [1:0] SRC_ASYN = 2'h3;
	localparam int         SAMPLE_SHORT = 4;
	localparam int         SAMPLE_LONG  = 24;
	localparam int         NBITS = 10;

	typedef struct packed {
		logic       aien;
		logic       adco;
		logic [4:0] ch;
	} sactc_sc1_t;

	typedef struct packed {
		logic       hw_trig;
		logic       cmp_en;
		logic       cmp_ge;
	} sactc_sc2_t;

	typedef struct packed {
		logic       low_power;
		logic [1:0] div;
		logic       long_sample;
		logic       mode10;
		logic [1:0] clk_src;
	} sactc_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_SAR    = 3'b100
	} sactc_state_t;
endpackage

// ===== core/sactc_core.sv
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module sactc_core
	import sactc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ext_reference_clock,
	input  wire logic        local_async_conv_clock,
	input  wire logic        hardware_trigger_in,
	input  wire logic        mcu_wait,
	input  wire logic        mcu_stop,
	input  wire logic        comparator_in,
	output logic      [4:0]  channel_select,
	output logic             sampling,
	output logic      [9:0]  dac_code,
	output logic             converter_on,
	output logic             adc_irq
);
	// ****************************************
	// Bus slave
	// ****************************************
	logic        wr_pend_q;
	logic        rd_pend_q;
	logic [7:0]  addr_q;
	sactc_sc1_t  sc1_q;
	sactc_sc2_t  sc2_q;
	sactc_cfg_t  cfg_q;
	logic [9:0]  cv_q;
	logic [9:0]  result_q;
	logic        conversion_done_flag;
	logic        active_q;
	sactc_state_t state_q;

	logic        take;
	logic        sc1_wr;
	logic        rl_rd;
	assign take      = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end else begin
			wr_pend_q <= take & hwrite;
			rd_pend_q <= take & ~hwrite;
			if (take)
				addr_q <= haddr[7:0];
		end
	end

	assign sc1_wr = wr_pend_q && addr_q == OFS_SC1;
	assign rl_rd  = take && !hwrite && haddr[7:0] == OFS_RL;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sc1_q <= '{aien: 1'b0, adco: 1'b0, ch: CH_OFF};
			sc2_q <= '0;
			cfg_q <= '0;
			cv_q  <= 10'h000;
		end else if (wr_pend_q) begin
			unique case (addr_q)
				OFS_SC1: sc1_q <= sactc_sc1_t'(hwdata[6:0]);
				OFS_SC2: sc2_q <= sactc_sc2_t'(hwdata[6:4]);
				OFS_CVH: cv_q[9:8] <= hwdata[1:0];
				OFS_CVL: cv_q[7:0] <= hwdata[7:0];
				OFS_CFG: cfg_q <= sactc_cfg_t'(hwdata[6:0]);
				default: ;
			endcase
		end
	end

	function automatic logic [9:0] fmt(input logic [9:0] r, input logic m10);
		fmt = m10 ? r : {2'b00, r[9:2]};
	endfunction

	logic [9:0] res_fmt;
	assign res_fmt = fmt(result_q, cfg_q.mode10);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (take && !hwrite) begin
			unique case (haddr[7:0])
				OFS_SC1: hrdata <= {24'h0, conversion_done_flag, sc1_q};
				OFS_SC2: hrdata <= {24'h0, active_q, sc2_q, 4'h0};
				OFS_RH:  hrdata <= {30'h0, res_fmt[9:8]};
				OFS_RL:  hrdata <= {24'h0, res_fmt[7:0]};
				OFS_CVH: hrdata <= {30'h0, cv_q[9:8]};
				OFS_CVL: hrdata <= {24'h0, cv_q[7:0]};
				OFS_CFG: hrdata <= {25'h0, cfg_q};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Conversion clock tick
	// ****************************************
	// Sources are sampled as levels in hclk; their rising edge gives a tick.
	// Trade-off: keeps one clock domain, so sources must be slower than hclk/2.
	logic [1:0] alt_s_q;
	logic [1:0] asy_s_q;
	logic       alt_d_q;
	logic       asy_d_q;
	logic       half_q;
	logic       src_tick;
	logic [3:0] div_cnt_q;
	logic [3:0] div_max;
	logic       conv_tick;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alt_s_q <= 2'b00;
			asy_s_q <= 2'b00;
			alt_d_q <= 1'b0;
			asy_d_q <= 1'b0;
			half_q  <= 1'b0;
		end else begin
			alt_s_q <= {alt_s_q[0], ext_reference_clock};
			asy_s_q <= {asy_s_q[0], local_async_conv_clock};
			alt_d_q <= alt_s_q[1];
			asy_d_q <= asy_s_q[1];
			half_q  <= ~half_q;
		end
	end

	always_comb begin
		unique case (cfg_q.clk_src)
			SRC_BUS:  src_tick = 1'b1;
			SRC_BUS2: src_tick = half_q;
			// Alternate runs in wait, blocked in stop
			SRC_ALT:  src_tick = alt_s_q[1] & ~alt_d_q & ~mcu_stop;
			SRC_ASYN: src_tick = asy_s_q[1] & ~asy_d_q;
			default:  src_tick = 1'b0;
		endcase
		// Bus clock sources stop in stop mode; wait keeps them.
		if (mcu_stop && cfg_q.clk_src != SRC_ASYN)
			src_tick = 1'b0;
	end

	assign div_max   = (4'h1 << cfg_q.div) - 4'h1;
	assign conv_tick = src_tick && div_cnt_q == div_max;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_cnt_q <= 4'h0;
		else if (src_tick)
			div_cnt_q <= conv_tick ? 4'h0 : div_cnt_q + 4'h1;
	end

	// ****************************************
	// Hardware trigger
	// ****************************************
	logic [1:0] trg_s_q;
	logic       trg_d_q;
	logic       hw_start;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trg_s_q <= 2'b00;
			trg_d_q <= 1'b0;
		end else begin
			trg_s_q <= {trg_s_q[0], hardware_trigger_in};
			trg_d_q <= trg_s_q[1];
		end
	end
	// No counter interrupt enable gating; no mode gating
	assign hw_start = sc2_q.hw_trig & trg_s_q[1] & ~trg_d_q;

	// ****************************************
	// Sequencer
	// ****************************************
	logic       ch_off;
	logic       sw_start;
	logic       start;
	logic [4:0] cnt_q;
	logic [3:0] bit_q;
	logic [9:0] sar_q;
	logic       finish;
	logic       match;
	logic [4:0] samp_len;
	logic       wr_off;

	assign ch_off   = sc1_q.ch == CH_OFF;
	assign wr_off   = sc1_wr && hwdata[4:0] == CH_OFF;
	assign sw_start = sc1_wr && hwdata[4:0] != CH_OFF && !sc2_q.hw_trig;
	assign start    = sw_start | (hw_start & ~ch_off & ~active_q);
	assign samp_len = 5'(cfg_q.long_sample ? SAMPLE_LONG : SAMPLE_SHORT);
	assign finish   = state_q == ST_SAR && conv_tick && bit_q == 4'h0;
	assign match    = sc2_q.cmp_ge ? sar_q >= cv_q : sar_q < cv_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q  <= ST_IDLE;
			cnt_q    <= 5'h00;
			bit_q    <= 4'h0;
			sar_q    <= 10'h000;
			active_q <= 1'b0;
		end else if (wr_off) begin
			state_q  <= ST_IDLE;
			active_q <= 1'b0;
		end else if (start || (sc1_wr && !sc2_q.hw_trig)) begin
			state_q  <= ST_SAMPLE;
			cnt_q    <= samp_len;
			active_q <= 1'b1;
		end else if (sc1_wr) begin
			state_q  <= ST_IDLE; // abort, wait for trigger
			active_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: ;
				ST_SAMPLE: if (conv_tick) begin
					if (cnt_q == 5'h00) begin
						state_q <= ST_SAR;
						bit_q   <= 4'(NBITS - 1);
						sar_q   <= 10'h200;
					end else
						cnt_q <= cnt_q - 5'h01;
				end
				ST_SAR: if (conv_tick) begin
					// keep or drop trial bit, set next
					if (!comparator_in)
						sar_q[bit_q] <= 1'b0;
					if (bit_q != 4'h0) begin
						sar_q[bit_q - 4'h1] <= 1'b1;
						bit_q <= bit_q - 4'h1;
					end else if (sc1_q.adco && !ch_off) begin
						state_q <= ST_SAMPLE;
						cnt_q   <= samp_len;
					end else begin
						state_q  <= ST_IDLE;
						active_q <= 1'b0;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Result and flag
	// ****************************************
	logic [9:0] final_val;
	logic       done_ok;
	assign final_val = comparator_in ? sar_q : sar_q & ~(10'h001);
	assign done_ok   = finish && (!sc2_q.cmp_en ||
		(sc2_q.cmp_ge ? final_val >= cv_q : final_val < cv_q));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_q             <= 10'h000;
			conversion_done_flag <= 1'b0;
		end else begin
			if (done_ok)
				result_q <= final_val;
			// Set beats the clear in the same cycle
			if (done_ok)
				conversion_done_flag <= 1'b1;
			else if (sc1_wr || rl_rd)
				conversion_done_flag <= 1'b0;
		end
	end

	assign adc_irq = conversion_done_flag & sc1_q.aien;

	// ****************************************
	// Analog front outputs
	// ****************************************
	assign channel_select = sc1_q.ch;
	assign sampling       = state_q == ST_SAMPLE;
	// Straight from the trial register: the comparator must judge this code
	// in the same tick, a further flop would lag one decision behind
	assign dac_code       = sar_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			converter_on <= 1'b0;
		else
			converter_on <= ~ch_off & (active_q | ~cfg_q.low_power);
	end
endmodule

// ===== testbench/sactc_props.sv
`timescale 1ns/1ps
module sactc_props
	import sactc_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        ext_reference_clock,
	input wire logic        local_async_conv_clock,
	input wire logic        hardware_trigger_in,
	input wire logic        mcu_wait,
	input wire logic        mcu_stop,
	input wire logic        comparator_in,
	input wire logic [4:0]  channel_select,
	input wire logic        sampling,
	input wire logic [9:0]  dac_code,
	input wire logic        converter_on,
	input wire logic        adc_irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ****************
	// Address decode
	// ****************
	wire logic take = hsel && hready && htrans[1];
	wire logic wr_sc1 = take && hwrite && haddr[7:0] == OFS_SC1;
	wire logic rd_rl = take && !hwrite && haddr[7:0] == OFS_RL;

	// ****************
	// Properties
	// ****************
	property p_ch_write;
		wr_sc1 |=> ##1 channel_select == $past(hwdata[4:0]);
	endproperty
	a_ch_write: assert property (p_ch_write)
		else $error("channel select not loaded from write");
	property p_sc1_clear;
		wr_sc1 |=> ##1 !adc_irq;
	endproperty
	a_sc1_clear: assert property (p_sc1_clear)
		else $error("done flag survives control write");
	property p_rl_clear;
		rd_rl |-> ##[1:2] !adc_irq;
	endproperty
	a_rl_clear: assert property (p_rl_clear)
		else $error("done flag survives low result read");
	property p_off;
		channel_select == CH_OFF [*3] |-> !sampling && !converter_on;
	endproperty
	a_off: assert property (p_off)
		else $error("converter runs with channel all ones");
	// A switch-off may cut a sample short
	property p_sample_len;
		$rose(sampling) |-> (sampling || channel_select == CH_OFF) [*5];
	endproperty
	a_sample_len: assert property (p_sample_len)
		else $error("sample window too short");
	// Trial code frozen while the input is sampled
	property p_dac_hold;
		sampling [*3] |-> $stable(dac_code);
	endproperty
	a_dac_hold: assert property (p_dac_hold)
		else $error("trial code moves while sampling");
	property p_irq_after_sar;
		$rose(adc_irq) |-> !$past(sampling, 8);
	endproperty
	a_irq_after_sar: assert property (p_irq_after_sar)
		else $error("done raised without full approximation");
	property p_okay;
		hresp == 1'b0 && hreadyout == 1'b1;
	endproperty
	a_okay: assert property (p_okay)
		else $error("bus answer not okay or not ready");

	c_sample: cover property ($rose(sampling));
	c_done: cover property ($rose(adc_irq));
	c_off: cover property ($fell(converter_on));
endmodule

// ===== testbench/sactc_afe_model.sv
`timescale 1ns/1ps
module sactc_afe_model (
	input wire logic       hclk,
	input wire logic       converter_on,
	input wire logic [9:0] dac_code,
	input wire logic [9:0] level,
	output logic           comparator_in
);
	logic tgl_q = 1'b0;

	// Powered down: no stable answer, so a toggling one
	always @(posedge hclk) begin
		tgl_q <= ~tgl_q;
	end
	assign comparator_in = converter_on ? level >= dac_code : tgl_q;
endmodule

// ===== testbench/sar_adc_clock_trigger_control_test.sv
`timescale 1ns/1ps
module sar_adc_clock_trigger_control_test;
	import sactc_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        ext_reference_clock = 1'b0;
	logic        local_async_conv_clock = 1'b0;
	logic        hardware_trigger_in = 1'b0;
	logic        mcu_wait = 1'b0;
	logic        mcu_stop = 1'b0;
	logic [9:0]  level = 10'h2a5;
	wire logic   hready, hreadyout, hresp, comparator_in;
	wire logic   sampling, converter_on, adc_irq;
	wire logic [31:0] hrdata;
	wire logic [9:0]  dac_code;
	wire logic [4:0]  channel_select;
	int          n_fail = 0;
	int          compares = 0;
	int          cyc = 0;
	logic [31:0] r;
	logic        seen;

	assign hready = hreadyout;
	always #20 hclk = ~hclk;
	// Slow sources land on falling edges only
	always #80 ext_reference_clock = ~ext_reference_clock;
	always #120 local_async_conv_clock = ~local_async_conv_clock;

	sactc_core DUT (.*);
	sactc_afe_model AFE (.*);

	// ****************
	// Helpers
	// ****************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task wirq(input int n);
		seen = 1'b0;
		for (int i = 0; i < n && !seen; i++) begin
			@(posedge hclk);
			seen = adc_irq === 1'b1;
		end
	endtask
	task conv(input logic [7:0] cfg, input logic w, input logic s,
		input logic [7:0] sc1, input logic exp);
		mcu_wait <= w;
		mcu_stop <= s;
		bus(1'b1, OFS_CFG, {24'h0, cfg});
		bus(1'b1, OFS_SC1, {24'h0, sc1});
		wirq(1500);
		chk(seen, exp);
		if (exp) begin
			bus(1'b0, OFS_RH, 32'h0);
			if (cfg[2]) chk(r, {30'h0, level[9:8]});
			bus(1'b0, OFS_RL, 32'h0);
			chk(r, {24'h0, cfg[2] ? level[7:0] : level[9:2]});
			wirq(100);
			chk(seen, 1'b0);
		end
		bus(1'b1, OFS_SC1, 32'h1f);
	endtask

	// ****************
	// Scenarios
	// ****************
	task t_reset;
		chk(channel_select, CH_OFF);
		bus(1'b1, 8'h40, 32'h5a);
		bus(1'b0, 8'h40, 32'h0);
		chk(r, 32'h0);
	endtask
	task t_sources;
		conv(8'h04, 1'b0, 1'b0, 8'h43, 1'b1);
		conv(8'h35, 1'b0, 1'b0, 8'h43, 1'b1);
		conv(8'h4e, 1'b1, 1'b0, 8'h43, 1'b1);
		conv(8'h06, 1'b0, 1'b1, 8'h43, 1'b0);
		conv(8'h0f, 1'b0, 1'b1, 8'h5a, 1'b1);
		conv(8'h03, 1'b0, 1'b0, 8'h5b, 1'b1);
	endtask
	task t_abort;
		bus(1'b1, OFS_CFG, 32'h04);
		bus(1'b1, OFS_SC1, 32'h43);
		repeat (9) @(posedge hclk);
		chk(sampling, 1'b0);
		bus(1'b1, OFS_SC1, 32'h43);
		repeat (2) @(posedge hclk);
		chk(sampling, 1'b1);
		wirq(10);
		chk(seen, 1'b0);
		wirq(1500);
		chk(seen, 1'b1);
		bus(1'b1, OFS_SC1, 32'h1f);
	endtask
	task t_trig;
		bus(1'b1, OFS_CFG, 32'h04);
		bus(1'b1, OFS_SC2, 32'h40);
		bus(1'b1, OFS_SC1, 32'h43);
		wirq(200);
		chk(seen, 1'b0);
		hardware_trigger_in <= 1'b1;
		repeat (3) @(posedge hclk);
		hardware_trigger_in <= 1'b0;
		wirq(1500);
		chk(seen, 1'b1);
		bus(1'b0, OFS_RL, 32'h0);
		chk(r, {24'h0, level[7:0]});
		wirq(300);
		chk(seen, 1'b0);
		bus(1'b1, OFS_SC2, 32'h0);
		bus(1'b1, OFS_SC1, 32'h1f);
	endtask
	task t_cmp;
		bus(1'b1, OFS_CVH, 32'h3);
		bus(1'b1, OFS_CVL, 32'h0);
		bus(1'b1, OFS_SC2, 32'h30);
		conv(8'h04, 1'b0, 1'b0, 8'h43, 1'b0);
		bus(1'b1, OFS_SC2, 32'h20);
		conv(8'h04, 1'b0, 1'b0, 8'h43, 1'b1);
		bus(1'b1, OFS_SC2, 32'h0);
	endtask
	task t_cont;
		bus(1'b1, OFS_CFG, 32'h04);
		bus(1'b1, OFS_SC1, 32'h63);
		wirq(1500);
		chk(seen, 1'b1);
		bus(1'b0, OFS_RL, 32'h0);
		wirq(1500);
		chk(seen, 1'b1);
		bus(1'b1, OFS_SC1, 32'h7f);
		wirq(300);
		chk(seen, 1'b0);
		chk({sampling, converter_on}, 2'h0);
	endtask

	task wrap_up;
		if (n_fail == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			wrap_up();
		end
	end

	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_sources();
		t_abort();
		t_trig();
		t_cmp();
		t_cont();
		wrap_up();
	end
endmodule

bind sactc_core sactc_props PROPS (.*);
